/* File: rtl/sma_pkg.sv */
package sma_pkg;

  // Register bus geometry
  localparam int               ADDR_W   = 8;
  localparam logic [ADDR_W-1:0] OFF_OPA  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_OPB  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACC  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CNT  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Count register fields
  localparam int CNT_AMT_MSB = 4;
  localparam int CNT_DIR_BIT = 5;
  localparam logic [7:0] CNT_WR_MASK = 8'h3f;

  // Status register fields
  localparam int STAT_BUSY_BIT = 7;
  localparam int STAT_ACCF_BIT = 6;
  localparam int STAT_ERR_BIT  = 5;

  // Reset values
  localparam logic [7:0]  RST_CNT = 8'h00;
  localparam logic [39:0] RST_ACC = 40'h0;
  localparam logic [2:0]  ACC_MSB_IDX = 3'h4;

  // Timing: oscillator period equals the bus clock period
  localparam int CLK_NS          = 40;
  localparam int TCLCL_NS        = 40;
  localparam int MC_TCLCL        = 4;
  localparam int EXEC_LONG_TCLCL  = 36;
  localparam int EXEC_SHORT_TCLCL = 24;
  localparam int BUSY_LONG_MC     = 9;
  localparam int BUSY_SHORT_MC    = 6;
  localparam int EXEC_LONG_CYC  = (EXEC_LONG_TCLCL * TCLCL_NS) / CLK_NS;
  localparam int EXEC_SHORT_CYC = (EXEC_SHORT_TCLCL * TCLCL_NS) / CLK_NS;
  localparam logic [5:0] RUN_LONG  = 6'((BUSY_LONG_MC * MC_TCLCL * TCLCL_NS) / CLK_NS);
  localparam logic [5:0] RUN_SHORT = 6'((BUSY_SHORT_MC * MC_TCLCL * TCLCL_NS) / CLK_NS);

  typedef enum logic [2:0] {PH_LOAD, PH_RUN, PH_READ, PH_ERR} sma_phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} sma_op_t;

endpackage

/* File: rtl/sma_math.sv */
`timescale 1ns/1ps
module sma_math (
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  input  wire logic [15:0] mcand,
  input  wire logic [15:0] mplier,
  input  wire logic [4:0]  sh_amt,
  input  wire logic        sh_right,
  output logic      [31:0] quot,
  output logic      [15:0] rem,
  output logic      [31:0] prod,
  output logic      [31:0] shifted,
  output logic      [31:0] mant,
  output logic      [4:0]  expo
);
  import sma_pkg::*;

  // Leading zero count, wraps to zero for an all-zero word
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       found;
    n = 5'h0;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found) begin
        if (v[i]) begin
          found = 1'b1;
        end else begin
          n = n + 5'h1;
        end
      end
    end
    return n;
  endfunction

  // Divide; a zero divisor saturates instead of trapping
  always_comb begin
    quot = 32'hffffffff;
    rem  = dividend[15:0];
    if (divisor != 16'h0) begin
      quot = dividend / {16'h0, divisor};
      rem  = 16'(dividend % {16'h0, divisor});
    end
  end

  // Multiply, shift and normalize
  assign prod    = {16'h0, mcand} * {16'h0, mplier};
  assign shifted = sh_right ? (dividend >> sh_amt) : (dividend << sh_amt);
  assign expo    = lead_zeros(dividend);
  assign mant    = dividend << expo;

endmodule

/* File: rtl/sma_top.sv */
// Behaviour
// - Operation chosen by order of operand and count register accesses, and by whether the count is zero.
// - 32/16 divide gives 32-bit quotient, 16-bit remainder within 36 clocks.
// - 16/16 divide gives 16-bit quotient, 16-bit remainder within 24 clocks.
// - Divide loads dividend into operand A LSB first, then divisor into B.
// - After divisor load busy holds 9 or 6 machine cycles, then clears.
// - Divide results: quotient from A MSB first, then remainder from B.
// - Multiply: B low/high, then A low/high; 32-bit product, 6 machine cycles.
// - Product read from operand A, four reads, MSB first.
// - Shift: four A bytes, then nonzero count and direction; 9 machine cycles.
// - Shift result read from operand A, four reads, MSB first.
// - Normalize gives 32-bit mantissa and 5-bit exponent in 36 clocks.
// - Zero count selects normalize; exponent read back from count field.
// - Busy flag set while executing, cleared on completion.
// - Unrelated register accesses between loads do not disturb sequencing.
// - Out-of-order access corrupts; only clearing busy restarts the sequencer.
// - Multiply products and divide quotients summed into 40-bit accumulator, no delay.
// - Accumulator: five writes LSB first, five reads MSB first, when not executing.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module sma_top (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sma_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [sma_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  import sma_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, OFF_OPA) | hit(a, OFF_OPB) | hit(a, OFF_ACC) | hit(a, OFF_CNT) |
           hit(a, OFF_STAT);
  endfunction

  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0]        wdata_r;
  logic              wstrb0_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [7:0]        rdata_r;
  logic              wr_do;
  logic              rd_do;
  logic              wa, wb, wacc, wcnt, abort;
  logic              ra, rb, racc;
  sma_phase_t        phase_r;
  sma_op_t           op_r;
  sma_op_t           go_op;
  logic [2:0]        a_cnt_r;
  logic [1:0]        b_cnt_r;
  logic              mul_first_r;
  logic [5:0]        run_cnt_r;
  logic [5:0]        go_len;
  logic [2:0]        rda_cnt_r;
  logic [1:0]        rdb_cnt_r;
  logic              seq_err, go, done, rd_last;
  logic [31:0]       opa_r;
  logic [15:0]       opb_r;
  logic [7:0]        cnt_r;
  logic [31:0]       res_r;
  logic [15:0]       rem_r;
  logic [39:0]       acc_r;
  logic [2:0]        acc_idx_r;
  logic [7:0]        rd_byte;
  logic [31:0]       m_dividend, m_quot, m_prod, m_shifted, m_mant;
  logic [15:0]       m_rem;
  logic [4:0]        m_expo;
  logic [5:0]        run_len_r;

  // Write channel: address and data taken in either order, one write in flight
  assign wr_do = !awready_r && !wready_r && !bvalid_r && !rd_do;
  assign rd_do = s_axi_arvalid && arready_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      awaddr_r  <= '0;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Read channel: side effects happen on the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 8'h00;
    end else if (rd_do) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_r   <= rd_byte;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // Decoded accesses; a write with byte lane 0 off is ignored
  assign wa    = wr_do && wstrb0_r && hit(awaddr_r, OFF_OPA);
  assign wb    = wr_do && wstrb0_r && hit(awaddr_r, OFF_OPB);
  assign wacc  = wr_do && wstrb0_r && hit(awaddr_r, OFF_ACC);
  assign wcnt  = wr_do && wstrb0_r && hit(awaddr_r, OFF_CNT);
  assign abort = wr_do && wstrb0_r && hit(awaddr_r, OFF_STAT) && !wdata_r[STAT_BUSY_BIT];
  assign ra    = rd_do && hit(s_axi_araddr, OFF_OPA);
  assign rb    = rd_do && hit(s_axi_araddr, OFF_OPB);
  assign racc  = rd_do && hit(s_axi_araddr, OFF_ACC);

  always_comb begin
    seq_err = 1'b0;
    go      = 1'b0;
    go_op   = OP_NONE;
    go_len  = RUN_LONG;
    rd_last = 1'b0;
    case (phase_r)
      PH_LOAD: begin
        if (wa) begin
          if (mul_first_r) begin
            seq_err = (b_cnt_r != 2'd2) || (a_cnt_r >= 3'd2);
            go      = !seq_err && (a_cnt_r == 3'd1);
            go_op   = OP_MUL;
            go_len  = RUN_SHORT;
          end else begin
            seq_err = (a_cnt_r >= 3'd4) || (b_cnt_r != 2'd0);
          end
        end
        if (wb) begin
          if (a_cnt_r == 3'd0) begin
            seq_err = (b_cnt_r >= 2'd2);
          end else begin
            seq_err = mul_first_r || (b_cnt_r >= 2'd2) ||
                      !((a_cnt_r == 3'd2) || (a_cnt_r == 3'd4));
            go      = !seq_err && (b_cnt_r == 2'd1);
            go_op   = (a_cnt_r == 3'd4) ? OP_DIV32 : OP_DIV16;
            go_len  = (a_cnt_r == 3'd4) ? RUN_LONG : RUN_SHORT;
          end
        end
        if (wcnt && !mul_first_r && (a_cnt_r == 3'd4) && (b_cnt_r == 2'd0)) begin
          go     = 1'b1;
          go_op  = (wdata_r[CNT_AMT_MSB:0] == 5'h0) ? OP_NORM : OP_SHIFT;
          go_len = RUN_LONG;
        end
        if (ra || rb) begin
          seq_err = 1'b1;
        end
      end
      PH_RUN: begin
        seq_err = wa || wb || ra || rb || wacc || racc;
      end
      PH_READ: begin
        if (ra) begin
          seq_err = (rda_cnt_r >= ((op_r == OP_DIV16) ? 3'd2 : 3'd4));
          rd_last = !seq_err && (op_r != OP_DIV32) && (op_r != OP_DIV16) &&
                    (rda_cnt_r == 3'd3);
        end
        if (rb) begin
          seq_err = !((op_r == OP_DIV32) && (rda_cnt_r == 3'd4)) &&
                    !((op_r == OP_DIV16) && (rda_cnt_r == 3'd2));
          seq_err = seq_err || (rdb_cnt_r >= 2'd2);
          rd_last = !seq_err && (rdb_cnt_r == 2'd1);
        end
        if (wa || wb) begin
          seq_err = 1'b1;
        end
      end
      PH_ERR: begin
        seq_err = 1'b0;
      end
      default: begin
        seq_err = 1'b0;
      end
    endcase
  end

  assign done = (phase_r == PH_RUN) && (run_cnt_r == 6'd1) && !seq_err && !abort;

  // Sequencer; a fault outranks a clear arriving in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r     <= PH_LOAD;
      op_r        <= OP_NONE;
      a_cnt_r     <= 3'd0;
      b_cnt_r     <= 2'd0;
      mul_first_r <= 1'b0;
      run_cnt_r   <= 6'd0;
      rda_cnt_r   <= 3'd0;
      rdb_cnt_r   <= 2'd0;
    end else if (seq_err) begin
      phase_r <= PH_ERR;
    end else if (abort) begin
      phase_r     <= PH_LOAD;
      a_cnt_r     <= 3'd0;
      b_cnt_r     <= 2'd0;
      mul_first_r <= 1'b0;
    end else begin
      case (phase_r)
        PH_LOAD: begin
          if (wa) begin
            a_cnt_r <= a_cnt_r + 3'd1;
          end
          if (wb) begin
            b_cnt_r <= b_cnt_r + 2'd1;
            if (a_cnt_r == 3'd0) begin
              mul_first_r <= 1'b1;
            end
          end
          if (go) begin
            phase_r   <= PH_RUN;
            op_r      <= go_op;
            run_cnt_r <= go_len;
          end
        end
        PH_RUN: begin
          if (run_cnt_r == 6'd1) begin
            phase_r   <= PH_READ;
            rda_cnt_r <= 3'd0;
            rdb_cnt_r <= 2'd0;
          end
          run_cnt_r <= run_cnt_r - 6'd1;
        end
        PH_READ: begin
          if (ra) begin
            rda_cnt_r <= rda_cnt_r + 3'd1;
          end
          if (rb) begin
            rdb_cnt_r <= rdb_cnt_r + 2'd1;
          end
          if (rd_last) begin
            phase_r     <= PH_LOAD;
            a_cnt_r     <= 3'd0;
            b_cnt_r     <= 2'd0;
            mul_first_r <= 1'b0;
          end
        end
        default: begin
          phase_r <= phase_r;
        end
      endcase
    end
  end

  // Operand shift-in; stray writes still land but the sequence is already faulted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opa_r <= 32'h0;
      opb_r <= 16'h0;
    end else begin
      if (wa) begin
        opa_r <= {wdata_r, opa_r[31:8]};
      end
      if (wb) begin
        opb_r <= {wdata_r, opb_r[15:8]};
      end
    end
  end

  assign m_dividend = ((op_r == OP_DIV16) || (op_r == OP_MUL)) ? {16'h0, opa_r[31:16]} : opa_r;

  sma_math u_math (
    .dividend (m_dividend),
    .divisor  (opb_r),
    .mcand    (opa_r[31:16]),
    .mplier   (opb_r),
    .sh_amt   (cnt_r[CNT_AMT_MSB:0]),
    .sh_right (cnt_r[CNT_DIR_BIT]),
    .quot     (m_quot),
    .rem      (m_rem),
    .prod     (m_prod),
    .shifted  (m_shifted),
    .mant     (m_mant),
    .expo     (m_expo)
  );

  // Results latched at completion, shifted out MSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_r <= 32'h0;
      rem_r <= 16'h0;
    end else if (done) begin
      case (op_r)
        OP_DIV32: res_r <= m_quot;
        OP_DIV16: res_r <= {m_quot[15:0], 16'h0};
        OP_MUL:   res_r <= m_prod;
        OP_SHIFT: res_r <= m_shifted;
        OP_NORM:  res_r <= m_mant;
        default:  res_r <= res_r;
      endcase
      rem_r <= m_rem;
    end else if (phase_r == PH_READ) begin
      if (ra) begin
        res_r <= {res_r[23:0], 8'h00};
      end
      if (rb) begin
        rem_r <= {rem_r[7:0], 8'h00};
      end
    end
  end

  // Count register; normalize writes its exponent back here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= RST_CNT;
    end else if (done && (op_r == OP_NORM)) begin
      cnt_r <= {cnt_r[7:CNT_AMT_MSB+1], m_expo};
    end else if (wcnt) begin
      cnt_r <= wdata_r & CNT_WR_MASK;
    end
  end

  // 40-bit accumulator, summed on the completing edge so no cycle is added
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r     <= RST_ACC;
      acc_idx_r <= ACC_MSB_IDX;
    end else if (done && (op_r == OP_MUL)) begin
      acc_r     <= acc_r + {8'h00, m_prod};
      acc_idx_r <= ACC_MSB_IDX;
    end else if (done && ((op_r == OP_DIV32) || (op_r == OP_DIV16))) begin
      acc_r     <= acc_r + {8'h00, m_quot};
      acc_idx_r <= ACC_MSB_IDX;
    end else if (wacc && (phase_r != PH_RUN)) begin
      acc_r     <= {wdata_r, acc_r[39:8]};
      acc_idx_r <= ACC_MSB_IDX;
    end else if (racc && (phase_r != PH_RUN)) begin
      acc_idx_r <= (acc_idx_r == 3'd0) ? ACC_MSB_IDX : acc_idx_r - 3'd1;
    end
  end

  // Read data selection
  always_comb begin
    rd_byte = 8'h00;
    if (hit(s_axi_araddr, OFF_OPA) && (phase_r == PH_READ)) begin
      rd_byte = res_r[31:24];
    end else if (hit(s_axi_araddr, OFF_OPB) && (phase_r == PH_READ)) begin
      rd_byte = rem_r[15:8];
    end else if (hit(s_axi_araddr, OFF_ACC) && (phase_r != PH_RUN)) begin
      rd_byte = acc_r[{acc_idx_r, 3'b000} +: 8];
    end else if (hit(s_axi_araddr, OFF_CNT)) begin
      rd_byte = cnt_r;
    end else if (hit(s_axi_araddr, OFF_STAT)) begin
      rd_byte[STAT_BUSY_BIT] = (phase_r == PH_RUN) || (phase_r == PH_ERR);
      rd_byte[STAT_ACCF_BIT] = (phase_r == PH_RUN);
      rd_byte[STAT_ERR_BIT]  = (phase_r == PH_ERR);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = {24'h0, rdata_r};

  // Cycles spent executing, watched by the checks below
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_len_r <= 6'd0;
    end else if (go && !seq_err && !abort) begin
      run_len_r <= 6'd1;
    end else if ((phase_r == PH_RUN) && !done) begin
      run_len_r <= run_len_r + 6'd1;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_mul_last_load;
    (phase_r == PH_LOAD) && wa && mul_first_r && (b_cnt_r == 2'd2) && (a_cnt_r == 3'd1);
  endsequence

  chk_div32_busy: assert property (done && (op_r == OP_DIV32)
                                   |-> run_len_r == EXEC_LONG_CYC)
    else $error("long divide busy length wrong");
  chk_div16_busy: assert property (done && (op_r == OP_DIV16)
                                   |-> run_len_r == EXEC_SHORT_CYC)
    else $error("short divide busy length wrong");
  chk_mul_busy: assert property (done && (op_r == OP_MUL) |-> run_len_r == EXEC_SHORT_CYC)
    else $error("multiply busy length wrong");
  chk_shift_busy: assert property (done && (op_r inside {OP_SHIFT, OP_NORM})
                                   |-> run_len_r == EXEC_LONG_CYC)
    else $error("shift or normalize busy length wrong");
  chk_mul_start: assert property (s_mul_last_load
                                  |=> (phase_r == PH_RUN) && (op_r == OP_MUL)
                                  ##(EXEC_SHORT_CYC) (phase_r != PH_RUN))
    else $error("multiply not started or not finished on time");
  chk_abort_idle: assert property (abort && !seq_err
                                   |=> (phase_r == PH_LOAD) && (a_cnt_r == 3'd0))
    else $error("clearing busy did not restart sequencer");
  chk_err_hold: assert property ((phase_r == PH_ERR) && !abort |=> phase_r == PH_ERR)
    else $error("fault left without clearing busy");
  chk_acc_add: assert property (done && (op_r == OP_MUL)
                                |=> acc_r == $past(acc_r) + {8'h00, $past(m_prod)})
    else $error("product not accumulated");
  chk_read_idle: assert property (rd_last && !abort
                                  |=> (phase_r == PH_LOAD) && !mul_first_r)
    else $error("sequencer not idle after last read");
  chk_quot_msb: assert property ((phase_r == PH_READ) && ra
                                 |=> s_axi_rdata[7:0] == $past(res_r[31:24]))
    else $error("result byte order wrong");

endmodule

/* File: tb/sma_top_tb.sv */
`timescale 1ns/1ps
module sma_top_tb;
  import sma_pkg::*;
  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr;
  logic              awvalid;
  logic              awready;
  logic [31:0]       wdata;
  logic [3:0]        wstrb;
  logic              wvalid;
  logic              wready;
  logic [1:0]        bresp;
  logic              bvalid;
  logic              bready;
  logic [ADDR_W-1:0] araddr;
  logic              arvalid;
  logic              arready;
  logic [31:0]       rdata;
  logic [1:0]        rresp;
  logic              rvalid;
  logic              rready;
  int                error_cnt;
  int                n_tests;
  int                cyc;
  logic [39:0]       acc_e;

  sma_top sma_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // 25 MHz clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Free cycle count, used to time the busy window
  always @(posedge aclk) begin
    cyc <= cyc + 1;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [39:0] e, logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // A lost handshake ends the run at once
  task automatic hang(string nm);
    $display("[FAIL] %s expected answer seen none", nm);
    error_cnt++;
    summarize();
  endtask

  // One byte write; address and data released each as taken
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h0, d};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang("write");
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) hang("read");
    chk("rresp", er, rresp);
    d = rdata;
  endtask

  // Whole word compare, so stray upper data bits are caught too
  task automatic rc(logic [7:0] a, logic [7:0] e, string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, {24'h0, e}, d);
  endtask

  task automatic wa(logic [7:0] a, logic [39:0] v, int nb);
    for (int i = 0; i < nb; i++) wr(a, v[8*i+:8]);
  endtask

  task automatic ra(logic [7:0] a, logic [39:0] e, int nb, string nm);
    for (int i = nb - 1; i >= 0; i--) rc(a, e[8*i+:8], nm);
  endtask

  // Poll busy; its span must lie between 4 below and 6 above the operation length
  task automatic wt(string nm, int len);
    logic [31:0] s;
    int          t0;
    t0 = cyc;
    rd(OFF_STAT, s);
    chk({nm, " busy set"}, 1'b1, s[STAT_BUSY_BIT]);
    chk({nm, " acc flag set"}, 1'b1, s[STAT_ACCF_BIT]);
    for (int n = 0; n < 60 && s[STAT_BUSY_BIT]; n++) rd(OFF_STAT, s);
    if (s[STAT_BUSY_BIT] !== 1'b0) hang(nm);
    chk({nm, " acc flag clear"}, 1'b0, s[STAT_ACCF_BIT]);
    chk({nm, " busy span"}, 1'b1, cyc - t0 >= len - 4 && cyc - t0 <= len + 6);
  endtask

  task automatic t_div(logic [31:0] x, logic [15:0] y, int nb);
    wa(OFF_OPA, x, nb);
    rc(OFF_CNT, 8'h00, "count between loads");
    wa(OFF_OPB, y, 2);
    wt("div", nb == 4 ? EXEC_LONG_CYC : EXEC_SHORT_CYC);
    ra(OFF_OPA, x / y, nb, "quotient");
    ra(OFF_OPB, x % y, 2, "remainder");
    acc_e += x / y;
  endtask

  task automatic t_mul(logic [15:0] a, logic [15:0] b);
    wa(OFF_OPB, b, 2);
    wa(OFF_OPA, a, 2);
    wt("mul", EXEC_SHORT_CYC);
    ra(OFF_OPA, 40'(a) * b, 4, "product");
    acc_e += 40'(a) * b;
  endtask

  task automatic t_sh(logic [31:0] x, logic [5:0] c);
    wa(OFF_OPA, x, 4);
    wr(OFF_CNT, {2'b00, c});
    wt("shift", EXEC_LONG_CYC);
    ra(OFF_OPA, c[5] ? x >> c[4:0] : x << c[4:0], 4, "shifted");
  endtask

  // Mantissa and exponent worked out by a plain leading-zero walk
  task automatic t_norm(logic [31:0] x);
    logic [31:0] m;
    int          e;
    m = x;
    for (e = 0; e < 31 && !m[31]; e++) m = m << 1;
    wa(OFF_OPA, x, 4);
    wr(OFF_CNT, 8'h00);
    wt("norm", EXEC_LONG_CYC);
    ra(OFF_OPA, m, 4, "mantissa");
    rc(OFF_CNT, 8'(e), "exponent");
  endtask

  // Read of operand B in mid-load, then clear, then unmapped place
  task automatic t_err();
    logic [31:0] s;
    wr(OFF_OPA, 8'h11);
    rd(OFF_OPB, s);
    rd(OFF_STAT, s);
    chk("error status", 2'b11, {s[STAT_BUSY_BIT], s[STAT_ERR_BIT]});
    wr(OFF_STAT, 8'h00);
    rd(OFF_STAT, s);
    chk("cleared status", 2'b00, {s[STAT_BUSY_BIT], s[STAT_ERR_BIT]});
    // A write with byte lane 0 off must leave the count alone
    wr(OFF_CNT, 8'h2a);
    wstrb <= 4'h0;
    wr(OFF_CNT, 8'h15);
    wstrb <= 4'h1;
    rc(OFF_CNT, 8'h2a, "count after masked write");
    wr(8'h20, 8'h5a, RESP_SLVERR);
    rd(8'h20, s, RESP_SLVERR);
    chk("unmapped data", 32'h0, s);
  endtask

  task automatic t_acc();
    // Sum of every earlier quotient and product
    ra(OFF_ACC, acc_e, 5, "accumulated results");
    acc_e = 40'h01_0000_00f0;
    wa(OFF_ACC, acc_e, 5);
    t_mul(16'hffff, 16'hffff);
    ra(OFF_ACC, acc_e, 5, "accumulator");
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr  = '0;
    awvalid = 1'b0;
    wdata   = '0;
    wstrb   = 4'h1;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = '0;
    arvalid = 1'b0;
    rready  = 1'b0;
    acc_e   = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(OFF_STAT, 8'h00, "status at reset");
    rc(OFF_CNT, 8'h00, "count at reset");
    t_div(32'h1234_5678, 16'h0123, 4);
    t_div(32'h0000_beef, 16'h0011, 2);
    t_mul(16'h1234, 16'habcd);
    t_sh(32'h80f0_0001, 6'h23);
    t_sh(32'h80f0_0001, 6'h05);
    t_norm(32'h0000_1234);
    t_err();
    t_mul(16'h00ff, 16'h0102);
    t_acc();
    summarize();
  end
endmodule
